// File: design/power_seq_pkg.sv
package power_seq_pkg;

  // clock and timing
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned STARTUP_DELAY_MS = 10;
  localparam int unsigned DELAY_CYCLES = STARTUP_DELAY_MS * CLK_MHZ * 1000;
  localparam int unsigned DELAY_W = 20;
  localparam int unsigned MIN_PULSE_NS = 25;
  localparam int unsigned MIN_ON_CYCLES = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // switching periods, from the rate in kHz, rounded down
  localparam int unsigned RATE_HIGH_KHZ = 2000;
  localparam int unsigned RATE_MID_KHZ = 1670;
  localparam int unsigned RATE_LOW_KHZ = 1000;
  localparam int unsigned PERIOD_W = 7;
  localparam logic [6:0] PERIOD_HIGH = 7'((CLK_MHZ * 1000) / RATE_HIGH_KHZ);
  localparam logic [6:0] PERIOD_MID = 7'((CLK_MHZ * 1000) / RATE_MID_KHZ);
  localparam logic [6:0] PERIOD_LOW = 7'((CLK_MHZ * 1000) / RATE_LOW_KHZ);
  // on-time ceiling is period minus period >> DUTY_SHIFT (87.5 %)
  localparam int unsigned DUTY_SHIFT = 3;

  // register offsets
  localparam logic [7:0] OFS_ENABLES = 8'h08;
  localparam logic [7:0] OFS_BOOST_LEVEL = 8'h0d;
  localparam logic [7:0] OFS_RATE_SELECT = 8'h0e;
  localparam logic [7:0] OFS_MODE_STATUS = 8'h0f;
  localparam logic [7:0] OFS_SOFT_RESET = 8'h60;

  // enables register fields
  localparam int unsigned BIT_RUN_ENABLE = 0;
  localparam int unsigned BIT_CONVERTER_ENABLE = 1;
  localparam int unsigned BIT_BLEED_LOAD_ENABLE = 2;

  // reset values
  localparam logic RST_RUN_ENABLE = 1'b0;
  localparam logic RST_CONVERTER_ENABLE = 1'b0;
  localparam logic RST_BLEED_LOAD_ENABLE = 1'b1;
  localparam logic [7:0] RST_BOOST_LEVEL = 8'h3f;
  localparam logic [2:0] RST_RATE_SELECT = 3'h7;

  typedef enum logic [4:0] {
    ST_RESET = 5'h01,
    ST_STANDBY = 5'h02,
    ST_STARTUP = 5'h04,
    ST_BOOST_START = 5'h08,
    ST_NORMAL = 5'h10
  } mode_t;

endpackage : power_seq_pkg

// File: design/boost_ctl_if.sv
interface boost_ctl_if;
  logic run;
  logic pfm;
  logic skip_ok;
  logic [6:0] period;
  logic fb_low;
  logic cur_trip;
  logic sw;

  modport ctl (output run, output pfm, output skip_ok, output period, output fb_low, output cur_trip, input sw);
  modport gen (input run, input pfm, input skip_ok, input period, input fb_low, input cur_trip, output sw);
endinterface : boost_ctl_if

// File: design/boost_switch_gen.sv
module boost_switch_gen (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control
  boost_ctl_if.gen bc
);

  typedef struct packed {
    logic [6:0] cnt;
    logic sw;
  } gen_state_t;

  gen_state_t q;
  gen_state_t d;
  logic [6:0] max_on;
  logic [6:0] width;
  logic start;

  always_comb begin
    d = q;
    max_on = bc.period - (bc.period >> power_seq_pkg::DUTY_SHIFT);
    width = q.cnt + 7'h01;
    // pfm, or pwm with the bleed load off, may skip; pwm otherwise always fires
    start = (bc.pfm || bc.skip_ok) ? bc.fb_low : 1'b1;
    if (!bc.run) begin
      d.cnt = 7'h00;
      d.sw = 1'b0;
    end else begin
      d.cnt = (width >= bc.period) ? 7'h00 : width;
      if (q.cnt == 7'h00 && !q.sw) begin
        d.sw = start;
      end else if (q.sw) begin
        if (width >= max_on) begin
          d.sw = 1'b0;
        end else if (bc.cur_trip && width >= 7'(power_seq_pkg::MIN_ON_CYCLES)) begin
          d.sw = 1'b0;
        end
      end
      if (width >= bc.period) begin
        d.sw = start;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bc.sw = q.sw;

endmodule : boost_switch_gen

// File: design/lighting_power_mode_sequencer.sv
module lighting_power_mode_sequencer #(
  parameter int unsigned DELAY_CYCLES = power_seq_pkg::DELAY_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // analog indications
  input wire logic i_power_on_clear,
  input wire logic i_overtemp_shutdown,
  input wire logic i_fb_low,
  input wire logic i_cur_trip,
  // power and converter controls
  output logic o_core_on,
  output logic o_boost_sw,
  output logic o_pfm_mode,
  output logic o_bleed_load,
  output logic o_led_enable,
  output logic [3:0] o_boost_level,
  output logic [4:0] o_mode
);

  typedef struct packed {
    power_seq_pkg::mode_t mode;
    logic [power_seq_pkg::DELAY_W-1:0] delay;
    logic run_enable;
    logic converter_enable;
    logic bleed_load_enable;
    logic [2:0] switch_rate_code;
    logic [7:0] boost_level_code;
    logic [7:0] rdata;
    logic core_on;
    logic led_enable;
    logic boost_run;
    logic pfm;
    logic bleed;
    logic [3:0] level;
    logic [6:0] period;
  } seq_state_t;

  seq_state_t q;
  seq_state_t d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic wr_enables;
  logic wr_soft_reset;
  logic conv_rise;
  logic conv_fall;
  logic delay_done;
  logic [7:0] level_src;

  boost_ctl_if bc ();

  // reset release through two flops
  // assertion stays asynchronous; only the release is synchronised
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // highest set bit decides the level
  // so a broken thermometer code still maps to one of the nine levels
  function automatic logic [3:0] level_decode(input logic [7:0] code);
    logic [3:0] lvl;
    lvl = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (code[i]) begin
        lvl = 4'(i + 1);
      end
    end
    return lvl;
  endfunction : level_decode

  // priority decode; an all-zero code falls through to the lowest rate
  function automatic logic [6:0] rate_decode(input logic [2:0] code);
    logic [6:0] per;
    if (code[2]) begin
      per = power_seq_pkg::PERIOD_HIGH;
    end else if (code[1]) begin
      per = power_seq_pkg::PERIOD_MID;
    end else begin
      per = power_seq_pkg::PERIOD_LOW;
    end
    return per;
  endfunction : rate_decode

  assign wr_enables = i_reg_wr && (i_reg_addr == power_seq_pkg::OFS_ENABLES);
  assign wr_soft_reset = i_reg_wr && (i_reg_addr == power_seq_pkg::OFS_SOFT_RESET);
  assign conv_rise = wr_enables && i_reg_wdata[power_seq_pkg::BIT_CONVERTER_ENABLE] && !q.converter_enable;
  assign conv_fall = wr_enables && !i_reg_wdata[power_seq_pkg::BIT_CONVERTER_ENABLE];
  // one counter times both waits; standby clears it, as does every other mode change but a drop to standby from start-up or soft start
  assign delay_done = (q.delay == power_seq_pkg::DELAY_W'(DELAY_CYCLES - 1));

  always_comb begin
    d = q;
    // register writes, any order and any bits, in every mode but reset
    // standby writes land at once, so they act as soon as the core powers up
    if (i_reg_wr && q.mode != power_seq_pkg::ST_RESET) begin
      unique case (i_reg_addr)
        power_seq_pkg::OFS_ENABLES: begin
          d.run_enable = i_reg_wdata[power_seq_pkg::BIT_RUN_ENABLE];
          d.converter_enable = i_reg_wdata[power_seq_pkg::BIT_CONVERTER_ENABLE];
          d.bleed_load_enable = i_reg_wdata[power_seq_pkg::BIT_BLEED_LOAD_ENABLE];
        end
        power_seq_pkg::OFS_BOOST_LEVEL: begin
          d.boost_level_code = i_reg_wdata;
        end
        power_seq_pkg::OFS_RATE_SELECT: begin
          d.switch_rate_code = i_reg_wdata[2:0];
        end
        default: begin
        end
      endcase
    end

    // register reads
    // read data holds until the next read strobe
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        power_seq_pkg::OFS_ENABLES: begin
          d.rdata = {5'h00, q.bleed_load_enable, q.converter_enable, q.run_enable};
        end
        power_seq_pkg::OFS_BOOST_LEVEL: begin
          d.rdata = q.boost_level_code;
        end
        power_seq_pkg::OFS_RATE_SELECT: begin
          d.rdata = {5'h00, q.switch_rate_code};
        end
        power_seq_pkg::OFS_MODE_STATUS: begin
          d.rdata = {3'h0, q.mode};
        end
        // unmapped offsets and the write-only reset offset read as zero
        default: begin
          d.rdata = 8'h00;
        end
      endcase
    end

    // mode sequencing
    unique case (q.mode)
      power_seq_pkg::ST_RESET: begin
        d.mode = power_seq_pkg::ST_STANDBY;
      end
      power_seq_pkg::ST_STANDBY: begin
        d.delay = '0;
        if (q.run_enable) begin
          d.mode = power_seq_pkg::ST_STARTUP;
        end
      end
      power_seq_pkg::ST_STARTUP: begin
        if (!q.run_enable) begin
          d.mode = power_seq_pkg::ST_STANDBY;
        end else if (i_overtemp_shutdown) begin
          // full delay again once the overtemp event has cleared
          d.delay = '0;
        end else if (delay_done) begin
          d.delay = '0;
          d.mode = q.converter_enable ? power_seq_pkg::ST_BOOST_START : power_seq_pkg::ST_NORMAL;
        end else begin
          d.delay = q.delay + 1'b1;
        end
      end
      power_seq_pkg::ST_BOOST_START: begin
        if (!q.run_enable) begin
          d.mode = power_seq_pkg::ST_STANDBY;
        end else if (i_overtemp_shutdown) begin
          d.delay = '0;
          d.mode = power_seq_pkg::ST_STARTUP;
        // converter stopped during soft start: nothing left to time
        end else if (!q.converter_enable) begin
          d.delay = '0;
          d.mode = power_seq_pkg::ST_NORMAL;
        end else if (delay_done) begin
          d.delay = '0;
          d.mode = power_seq_pkg::ST_NORMAL;
        end else begin
          d.delay = q.delay + 1'b1;
        end
      end
      power_seq_pkg::ST_NORMAL: begin
        d.delay = '0;
        if (!q.run_enable) begin
          d.mode = power_seq_pkg::ST_STANDBY;
        end else if (i_overtemp_shutdown) begin
          d.mode = power_seq_pkg::ST_STARTUP;
        // only a low-to-high converter_enable write restarts the soft start
        end else if (conv_rise) begin
          d.mode = power_seq_pkg::ST_BOOST_START;
        end
      end
      default: begin
        d.mode = power_seq_pkg::ST_RESET;
      end
    endcase

    // soft reset write or power-on clear overrides everything
    // a register write in the same cycle is lost to the reset
    if (wr_soft_reset || i_power_on_clear) begin
      d.mode = power_seq_pkg::ST_RESET;
    end

    // reset mode restores every register
    if (d.mode == power_seq_pkg::ST_RESET) begin
      d.delay = '0;
      d.run_enable = power_seq_pkg::RST_RUN_ENABLE;
      d.converter_enable = power_seq_pkg::RST_CONVERTER_ENABLE;
      d.bleed_load_enable = power_seq_pkg::RST_BLEED_LOAD_ENABLE;
      d.switch_rate_code = power_seq_pkg::RST_RATE_SELECT;
      d.boost_level_code = power_seq_pkg::RST_BOOST_LEVEL;
    end

    // outputs, registered from the next mode and settings
    // taken from the next state so they change together with o_mode
    d.core_on = (d.mode == power_seq_pkg::ST_STARTUP) || (d.mode == power_seq_pkg::ST_BOOST_START)
      || (d.mode == power_seq_pkg::ST_NORMAL);
    d.boost_run = ((d.mode == power_seq_pkg::ST_BOOST_START) || (d.mode == power_seq_pkg::ST_NORMAL))
      && d.converter_enable && !(conv_fall && q.mode == power_seq_pkg::ST_NORMAL);
    d.pfm = (d.mode == power_seq_pkg::ST_BOOST_START);
    d.led_enable = (d.mode == power_seq_pkg::ST_NORMAL);
    d.bleed = d.boost_run && d.bleed_load_enable;
    level_src = d.boost_level_code;
    d.level = level_decode(level_src);
    d.period = rate_decode(d.switch_rate_code);
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      q.mode <= power_seq_pkg::ST_RESET;
      q.delay <= '0;
      q.run_enable <= power_seq_pkg::RST_RUN_ENABLE;
      q.converter_enable <= power_seq_pkg::RST_CONVERTER_ENABLE;
      q.bleed_load_enable <= power_seq_pkg::RST_BLEED_LOAD_ENABLE;
      q.switch_rate_code <= power_seq_pkg::RST_RATE_SELECT;
      q.boost_level_code <= power_seq_pkg::RST_BOOST_LEVEL;
      q.rdata <= 8'h00;
      q.core_on <= 1'b0;
      q.led_enable <= 1'b0;
      q.boost_run <= 1'b0;
      q.pfm <= 1'b0;
      q.bleed <= 1'b0;
      q.level <= 4'h6;
      q.period <= power_seq_pkg::PERIOD_HIGH;
    end else begin
      q <= d;
    end
  end

  // converter switch generator
  // fed from the next state: the switch stops at the very edge at which
  // the mode leaves the powered states or converter_enable is cleared
  assign bc.run = d.boost_run;
  assign bc.pfm = d.pfm;
  assign bc.skip_ok = !d.bleed_load_enable;
  assign bc.period = d.period;
  assign bc.fb_low = i_fb_low;
  assign bc.cur_trip = i_cur_trip;

  boost_switch_gen u_gen (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .bc(bc.gen)
  );

  assign o_reg_rdata = q.rdata;
  assign o_core_on = q.core_on;
  assign o_boost_sw = bc.sw;
  assign o_pfm_mode = q.pfm;
  assign o_bleed_load = q.bleed;
  assign o_led_enable = q.led_enable;
  assign o_boost_level = q.level;
  assign o_mode = q.mode;

endmodule : lighting_power_mode_sequencer

// File: tb/power_seq_sva.sv
module power_seq_sva #(
  parameter int unsigned DELAY_CYCLES = 20
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  // indications
  input wire logic i_power_on_clear,
  input wire logic i_overtemp_shutdown,
  // controls
  input wire logic o_core_on,
  input wire logic o_boost_sw,
  input wire logic o_pfm_mode,
  input wire logic o_bleed_load,
  input wire logic o_led_enable,
  input wire logic [4:0] o_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] prev_q;
  int unsigned run_q;
  int unsigned high_q;

  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // length of the mode run just ended, and switch on-time so far
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_q <= 5'h01;
      run_q <= 32'h0;
      high_q <= 32'h0;
    end else begin
      prev_q <= o_mode;
      run_q <= (o_mode == prev_q) ? run_q + 32'h1 : 32'h1;
      high_q <= o_boost_sw ? high_q + 32'h1 : 32'h0;
    end
  end

  a_pfm_in_boost: assert property (o_pfm_mode == (o_mode == 5'h08))
    else $error("soft start flag does not match mode");
  a_led_normal_only: assert property (o_led_enable |-> o_mode == 5'h10)
    else $error("leds enabled outside normal mode");
  a_standby_quiet: assert property (o_mode inside {5'h01, 5'h02} |->
    !(o_core_on | o_boost_sw | o_pfm_mode | o_bleed_load | o_led_enable))
    else $error("functions active while unpowered");
  a_soft_reset_entry: assert property (i_reg_wr && i_reg_addr == 8'h60 && o_mode != 5'h01 |=> o_mode == 5'h01)
    else $error("soft reset write did not enter reset");
  a_poc_hold: assert property (i_power_on_clear |=> o_mode == 5'h01)
    else $error("power on clear did not hold reset");
  a_reset_exit: assert property (o_mode == 5'h01 && !i_power_on_clear |->
    ##[1:4] (o_mode == 5'h02 || i_power_on_clear))
    else $error("reset did not proceed to standby");
  a_startup_delay: assert property (prev_q == 5'h04 && o_mode inside {5'h08, 5'h10} |->
    run_q >= DELAY_CYCLES - 1)
    else $error("start-up left too early");
  a_softstart_len: assert property (prev_q == 5'h08 && o_mode == 5'h10 |->
    run_q >= DELAY_CYCLES - 1 && run_q <= DELAY_CYCLES + 2)
    else $error("soft start length wrong");
  a_conv_off_hold: assert property (i_reg_wr && i_reg_addr == 8'h08 && i_reg_wdata[1:0] == 2'b01 &&
    o_mode == 5'h10 && !i_overtemp_shutdown |=> ##1 (o_mode == 5'h10 && !o_boost_sw)[*4])
    else $error("converter stop changed mode or kept switching");
  a_duty_ceiling: assert property (high_q <= 32'd88)
    else $error("switch on-time above ceiling");
endmodule : power_seq_sva

bind lighting_power_mode_sequencer power_seq_sva #(.DELAY_CYCLES(DELAY_CYCLES)) i_power_seq_sva (
  .i_clk, .i_rst_n, .i_reg_wr, .i_reg_addr, .i_reg_wdata, .i_power_on_clear, .i_overtemp_shutdown,
  .o_core_on, .o_boost_sw, .o_pfm_mode, .o_bleed_load, .o_led_enable, .o_mode
);

// File: tb/host_model.sv
module host_model (
  // clock
  input wire logic i_clk,
  // register port
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h5a;
    o_wdata = 8'ha5;
  end

  // any data to any offset: strobe, address and data for one cycle, then address and data inverted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_rd = 1'b1;
    o_addr = a;
    @(posedge i_clk);
    #1;
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
  endtask : rd
endmodule : host_model

// File: tb/tb.sv
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic poc = 1'b0;
  logic ot = 1'b0;
  logic fb = 1'b1;
  logic trip = 1'b1;
  logic wr, rd, core_on, sw, pfm, bleed, led;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] lvl;
  logic [4:0] mode;
  int err_count = 0;
  int compares = 0;

  always #5 clk = ~clk;

  host_model i_host_model (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata), .i_rdata(rdata));

  lighting_power_mode_sequencer #(.DELAY_CYCLES(20)) i_lighting_power_mode_sequencer (
    .i_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .i_power_on_clear(poc), .i_overtemp_shutdown(ot), .i_fb_low(fb), .i_cur_trip(trip),
    .o_core_on(core_on), .o_boost_sw(sw), .o_pfm_mode(pfm), .o_bleed_load(bleed), .o_led_enable(led),
    .o_boost_level(lvl), .o_mode(mode));

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic wait_mode(input logic [4:0] m);
    int n = 0;
    while (mode !== m && n < 500) begin
      tick();
      n++;
    end
    `CHK(mode, m)
  endtask : wait_mode

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host_model.rd(a, d);
    `CHK(d, e)
  endtask : rd_chk

  task automatic meas(output int per, output int wid);
    per = 0;
    while (sw !== 1'b0 && per < 200) begin tick(); per++; end
    while (sw !== 1'b1 && per < 400) begin tick(); per++; end
    per = 0;
    while (sw === 1'b1 && per < 200) begin tick(); per++; end
    wid = per;
    while (sw !== 1'b1 && per < 200) begin tick(); per++; end
  endtask : meas

  // cycles with the switch on, over 200 cycles
  task automatic on_count(output int n);
    n = 0;
    repeat (200) begin tick(); if (sw === 1'b1) n++; end
  endtask : on_count

  task automatic t_defaults();
    rd_chk(8'h0e, 8'h07);
    rd_chk(8'h0d, 8'h3f);
    rd_chk(8'h08, 8'h04);
    rd_chk(8'h0f, 8'h02);
    rd_chk(8'h33, 8'h00);
    rd_chk(8'h60, 8'h00);
    `CHK(lvl, 4'h6)
  endtask : t_defaults

  task automatic t_levels();
    logic [7:0] codes[11] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0f, 8'h1f, 8'h3f, 8'h7f, 8'hff, 8'h05, 8'h80};
    logic [3:0] lv[11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h3, 4'h8};
    foreach (codes[i]) begin
      i_host_model.wr(8'h0d, codes[i]);
      tick();
      `CHK(lvl, lv[i])
    end
  endtask : t_levels

  task automatic t_power_up();
    i_host_model.wr(8'h08, 8'h07);
    wait_mode(5'h04);
    `CHK(core_on, 1'b1)
    wait_mode(5'h08);
    `CHK({pfm, led}, 2'b10)
    wait_mode(5'h10);
    `CHK({pfm, led}, 2'b01)
  endtask : t_power_up

  task automatic t_rates();
    logic [2:0] rc[6] = '{3'h7, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
    int rp[6] = '{50, 50, 59, 59, 100, 100};
    // on-time ceiling of 87.5 % of each period, with the current trip held off
    int rw[6] = '{44, 44, 52, 52, 88, 88};
    int per, wid;
    foreach (rc[i]) begin
      i_host_model.wr(8'h0e, {5'h00, rc[i]});
      meas(per, wid);
      meas(per, wid);
      `CHK(per, rp[i])
      `CHK(wid, 3)
      trip = 1'b0;
      meas(per, wid);
      meas(per, wid);
      `CHK(wid, rw[i])
      `CHK(per, rp[i])
      trip = 1'b1;
    end
  endtask : t_rates

  task automatic t_bleed();
    int n;
    fb = 1'b0;
    i_host_model.wr(8'h08, 8'h03);
    `CHK(bleed, 1'b0)
    on_count(n);
    `CHK(n, 0)
    i_host_model.wr(8'h08, 8'h07);
    on_count(n);
    `CHK({bleed, n > 0}, 2'b11)
    fb = 1'b1;
  endtask : t_bleed

  task automatic t_conv();
    int n = 0;
    while (sw !== 1'b0 && n < 200) begin tick(); n++; end
    i_host_model.wr(8'h08, 8'h05);
    on_count(n);
    `CHK(n, 0)
    `CHK(mode, 5'h10)
    i_host_model.wr(8'h08, 8'h07);
    wait_mode(5'h08);
    wait_mode(5'h10);
  endtask : t_conv

  task automatic t_overtemp();
    ot = 1'b1;
    wait_mode(5'h04);
    repeat (50) tick();
    `CHK({mode, led}, 6'h08)
    ot = 1'b0;
    wait_mode(5'h08);
    wait_mode(5'h10);
  endtask : t_overtemp

  task automatic t_resets();
    i_host_model.wr(8'h08, 8'h00);
    wait_mode(5'h02);
    `CHK(core_on, 1'b0)
    i_host_model.wr(8'h08, 8'h05);
    wait_mode(5'h10);
    i_host_model.wr(8'h0e, 8'h01);
    i_host_model.wr(8'h60, 8'ha5);
    `CHK(mode, 5'h01)
    wait_mode(5'h02);
    rd_chk(8'h0e, 8'h07);
    rd_chk(8'h08, 8'h04);
    poc = 1'b1;
    repeat (10) tick();
    `CHK(mode, 5'h01)
    poc = 1'b0;
    wait_mode(5'h02);
  endtask : t_resets

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (4) tick();
    t_defaults();
    t_levels();
    t_power_up();
    t_rates();
    t_bleed();
    t_conv();
    t_overtemp();
    t_resets();
    conclude();
  end

  initial begin
    #300us;
    err_count++;
    conclude();
  end
endmodule : tb
